//--- verilog/cuc_unit_ctrl.sv
`timescale 1ns/1ns
module cuc_unit_ctrl
    import cuc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // exchange side
    input  wire logic [7:0] exch_in,
    input  wire logic       exch_load,
    input  wire logic       recirc_load,
    input  wire logic       translate_en,
    output logic [7:0]      exch_out,
    output logic            exch_out_valid,
    // status counter control
    input  wire logic       stc_advance,
    input  wire logic       stc_clear,
    input  wire logic       test_sr_cmd,
    output logic [4:0]      status_counter,
    output logic [4:0]      result_status,
    output logic [6:0]      byte_counter,
    // card cycle setup
    input  wire logic       cycle_req,
    input  wire logic       cfg_inhibit_feed,
    input  wire logic [2:0] cfg_stacker,
    input  wire logic       cfg_secondary,
    input  wire logic       cfg_punch,
    input  wire logic       cfg_print,
    input  wire logic       cfg_separate,
    input  wire logic       read_wanted,
    output logic            cycle_busy,
    // card unit lines
    input  wire logic       unit_ready,
    input  wire logic       card_cycle_in_progress,
    input  wire logic       char_needed,
    input  wire logic       read_buffer_full,
    input  wire logic       read_data_available,
    input  wire logic [7:0] read_data_lines,
    output logic            card_cycle_start,
    output logic            inhibit_feed,
    output logic [2:0]      stacker_select_levels,
    output logic            separate_print,
    output logic [7:0]      punch_print_lines,
    output logic            char_load_pulse,
    output logic            clear_read_buffer,
    output logic            read_transfer_clock
);
    cuc_cycle_t cyc;
    cuc_read_t  rd;
    logic [7:0] in_reg;
    logic [7:0] out_reg;
    logic       in_pending;
    logic       shift_busy;
    logic       shift_done;
    logic [7:0] shift_out;
    logic       punch_char_ok;

    // six-bit card code to eight-bit code and back
    function automatic logic [7:0] card_to_byte(input logic [5:0] c);
        card_to_byte = (c[5:4] == 2'h0) ? {4'hf, c[3:0]} :
                       {2'h3 - c[5:4], 2'h0, c[3:0]} + 8'h80;
    endfunction
    function automatic logic [5:0] byte_to_card(input logic [7:0] b);
        byte_to_card = (b[7:4] == 4'hf) ? {2'h0, b[3:0]} :
                       {2'h3 - (b[7:6] ^ 2'h2), b[3:0]};
    endfunction

    // input register: every stored value passes here first
    // an exchange load wins the input register, so the read waits instead of losing its character
    wire        read_take  = (rd == RD_IDLE) && read_data_available && read_wanted && !in_pending && !exch_load;
    wire [7:0]  read_byte  = translate_en ? card_to_byte(read_data_lines[5:0])
                                          : {2'h0, read_data_lines[5:0]};
    wire [1:0]  next_src   = exch_load ? SRC_EXCH : (read_take ? SRC_READ : SRC_RECIRC);
    wire        in_load    = (exch_load || read_take || recirc_load) && !in_pending;
    wire [7:0]  next_in    = (next_src == SRC_EXCH) ? exch_in :
                             (next_src == SRC_READ) ? read_byte : out_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_reg     <= BYTE_RESET;
            in_pending <= 1'b0;
        end else if (in_load) begin
            in_reg     <= next_in;
            in_pending <= 1'b1;
        end else if (shift_done) begin
            in_pending <= 1'b0;
        end
    end

    cuc_shift_store #(
        .DEPTH  (STORE_DEPTH),
        .PHASES (SHIFT_PHASES)
    ) u_store (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .shift_req  (in_pending && !shift_busy && !shift_done),
        .shift_in   (in_reg),
        .shift_busy (shift_busy),
        .shift_done (shift_done),
        .shift_out  (shift_out)
    );

    // output holding register catches each byte leaving the store
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_reg        <= BYTE_RESET;
            exch_out_valid <= 1'b0;
        end else begin
            exch_out_valid <= shift_done;
            if (shift_done) begin
                out_reg <= shift_out;
            end
        end
    end
    assign exch_out = out_reg;

    // status and byte counters
    wire [4:0] next_stc = (stc_clear || status_counter == STC_LAST) ? 5'h00 : status_counter + 5'h01;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_counter <= 5'h00;
            result_status  <= 5'h00;
            byte_counter   <= BYTE_COUNTER_RESET;
        end else begin
            if (stc_advance || stc_clear) begin
                status_counter <= next_stc;
            end
            if (!test_sr_cmd) begin
                result_status <= status_counter;
            end
            if (stc_clear) begin
                byte_counter <= BYTE_COUNTER_RESET;
            end else if (shift_done && status_counter == STC_BYTE) begin
                byte_counter <= byte_counter + 7'h01;
            end
        end
    end

    // card cycle: hold start until unit answers or drops ready
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc <= CYC_IDLE;
        end else begin
            case (cyc)
                CYC_IDLE: begin
                    if (cycle_req && unit_ready && !card_cycle_in_progress) begin
                        cyc <= CYC_START;
                    end
                end
                CYC_START: begin
                    if (card_cycle_in_progress) begin
                        cyc <= CYC_RUN;
                    end else if (!unit_ready) begin
                        cyc <= CYC_IDLE;
                    end
                end
                CYC_RUN: begin
                    if (!card_cycle_in_progress) begin
                        cyc <= CYC_IDLE;
                    end
                end
                default: cyc <= CYC_IDLE;
            endcase
        end
    end
    assign card_cycle_start      = (cyc == CYC_START);
    assign cycle_busy            = (cyc != CYC_IDLE);
    assign inhibit_feed          = cfg_inhibit_feed;
    assign stacker_select_levels = cfg_stacker;
    assign separate_print        = cfg_separate && cfg_punch && cfg_print;

    // punch character path: qualifiers ride lines 8, B, C until data flows
    assign punch_char_ok = char_needed && exch_out_valid && cycle_busy;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            punch_print_lines <= 8'h00;
            char_load_pulse   <= 1'b0;
        end else begin
            char_load_pulse <= punch_char_ok;
            if (punch_char_ok) begin
                punch_print_lines <= {2'h0, translate_en ? byte_to_card(out_reg) : out_reg[5:0]};
            end else if (!char_load_pulse) begin
                punch_print_lines <= 8'h00;
                punch_print_lines[LINE_8] <= cfg_secondary;
                punch_print_lines[LINE_B] <= cfg_punch;
                punch_print_lines[LINE_C] <= cfg_print;
            end
        end
    end

    // read unload: capture, then transfer clock, or clear when unwanted
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd <= RD_IDLE;
        end else begin
            case (rd)
                RD_IDLE:  if (read_take) rd <= RD_PULSE;
                RD_PULSE: rd <= RD_WAIT;
                RD_WAIT:  if (!read_data_available) rd <= RD_IDLE;
                default:  rd <= RD_IDLE;
            endcase
        end
    end
    assign read_transfer_clock = (rd == RD_PULSE);
    assign clear_read_buffer   = read_buffer_full && !read_wanted;

    start_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (card_cycle_start && unit_ready && !card_cycle_in_progress) |=> card_cycle_start)
        else $error("start level dropped early");
    start_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (card_cycle_start && card_cycle_in_progress) |=> !card_cycle_start)
        else $error("start level held after answer");
    no_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(card_cycle_start) |-> !$past(card_cycle_in_progress))
        else $error("start raised during cycle");
    stc_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        status_counter <= STC_LAST)
        else $error("status counter out of range");
    byte_count_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (shift_done && status_counter == STC_BYTE && !stc_clear) |=> byte_counter == $past(byte_counter) + 7'h01)
        else $error("byte counter missed a shift");
    xfer_clock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        read_take |=> read_transfer_clock ##1 !read_transfer_clock)
        else $error("transfer clock not a single pulse after capture");
    char_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        char_load_pulse |-> $past(char_needed) && punch_print_lines[7:6] == 2'h0)
        else $error("character wider than six lines");
    clear_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clear_read_buffer |-> !read_transfer_clock)
        else $error("clear and transfer clock together");
    cycle_c: cover property (@(posedge ref_clk) card_cycle_start ##[1:20] card_cycle_in_progress);
    punch_c: cover property (@(posedge ref_clk) char_load_pulse);
    read_c:  cover property (@(posedge ref_clk) read_transfer_clock ##[1:20] read_transfer_clock);
endmodule

//--- verilog/cuc_pkg.sv
// Functional notes
// - output holding register feeds input, exchange, punch lines
// - 100 by 8 store, four clocks per shift
// - store holds data plus three address bytes
// - status counter counts 00 to 23, reported
// - byte counter increments on shift at count ten
// - hold start until cycle in progress or not ready
// - three weighted stacker select levels driven
// - secondary path shares punch line 8
// - punch and print enables share lines B, C
// - separate print says printed data differs
// - load pulse latches character, drops request
// - six lines carry character, strobed by pulse
// - clear read buffer replaces transfer clocks
// - transfer clock pulse after capturing read character
// - no new cycle while cycle in progress
// - all stored values pass through input register
package cuc_pkg;
    localparam int        STORE_DEPTH   = 100;
    localparam int        SHIFT_PHASES  = 4;
    localparam int        ADDR_BYTES    = 3;
    localparam logic [4:0] STC_LAST     = 5'h17;
    localparam logic [4:0] STC_BYTE     = 5'h0a;
    localparam logic [6:0] BYTE_COUNTER_RESET   = 7'h00;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    // input register sources
    localparam logic [1:0] SRC_EXCH     = 2'h0;
    localparam logic [1:0] SRC_READ     = 2'h1;
    localparam logic [1:0] SRC_RECIRC   = 2'h2;
    // punch/print line positions (D C B A 8 4 2 1)
    localparam int        LINE_8        = 3;
    localparam int        LINE_B        = 5;
    localparam int        LINE_C        = 6;
    typedef enum logic [1:0] {
        CYC_IDLE  = 2'b00,
        CYC_START = 2'b01,
        CYC_RUN   = 2'b10
    } cuc_cycle_t;
    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,
        RD_PULSE = 2'b01,
        RD_WAIT  = 2'b10
    } cuc_read_t;
endpackage

//--- verilog/cuc_shift_store.sv
`timescale 1ns/1ns
module cuc_shift_store
    import cuc_pkg::*;
#(
    parameter int DEPTH  = STORE_DEPTH,
    parameter int PHASES = SHIFT_PHASES
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // shift request and data
    input  wire logic       shift_req,
    input  wire logic [7:0] shift_in,
    output logic            shift_busy,
    output logic            shift_done,
    output logic [7:0]      shift_out
);
    // store must also hold the three reference address bytes
    if (DEPTH <= ADDR_BYTES || PHASES < 2 || PHASES > 8) begin : bad_params
        $error("store depth or phases out of range");
    end

    logic [7:0] cells [DEPTH];
    logic [2:0] phase;
    wire        last_phase = (phase == 3'(PHASES - 1));

    assign shift_busy = (phase != 3'h0);

    // one advance of the whole register spans four clock periods
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase      <= 3'h0;
            shift_done <= 1'b0;
        end else begin
            shift_done <= shift_busy && last_phase;
            if (shift_busy) begin
                phase <= last_phase ? 3'h0 : phase + 3'h1;
            end else if (shift_req) begin
                phase <= 3'h1;
            end
        end
    end

    // storage itself carries no reset, as in a dynamic MOS store
    always_ff @(posedge ref_clk) begin
        if (shift_busy && last_phase) begin
            // take the byte as it falls off the end, so it leaves exactly DEPTH shifts after entry
            shift_out <= cells[DEPTH-1];
            cells[0] <= shift_in;
            for (int i = 1; i < DEPTH; i++) begin
                cells[i] <= cells[i-1];
            end
        end
    end

    shift_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (shift_req && !shift_busy) |-> ##3 shift_done == 1'b0 ##1 shift_done)
        else $error("shift did not complete in four clocks");
endmodule

//--- dv/cuc_card_unit_model.sv
`timescale 1ns/1ns
module cuc_card_unit_model #(
    parameter int COLS = 96,
    parameter int HOLD = 150
) (
    // pacing
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] dly,
    input  wire logic       unit_ready,
    // from control
    input  wire logic       card_cycle_start,
    input  wire logic       inhibit_feed,
    input  wire logic       char_load_pulse,
    input  wire logic       clear_read_buffer,
    input  wire logic       read_transfer_clock,
    // to control
    output logic            card_cycle_in_progress,
    output logic            char_needed,
    output logic            read_buffer_full,
    output logic            read_data_available,
    output logic [7:0]      read_data_lines
);
    logic [7:0] cnt;
    logic [6:0] cols;
    logic [7:0] last;
    logic       feed;
    // released lines show the inverse of the last character, never a stale copy
    assign read_data_lines = read_data_available ? {2'h0, 6'(cols * 7'h05)} : ~last;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {card_cycle_in_progress, char_needed, read_buffer_full, read_data_available, feed} <= '0;
            cnt  <= '0;
            cols <= '0;
            last <= '0;
        end else begin
            cnt <= cnt + 8'h01;
            if (read_data_available) last <= read_data_lines;
            if (!card_cycle_in_progress) begin
                if (!card_cycle_start || !unit_ready) cnt <= '0;
                else if (cnt == 8'(dly)) begin
                    card_cycle_in_progress <= 1'b1;
                    cnt  <= '0;
                    feed <= !inhibit_feed;
                end
            end else if (cnt == 8'(HOLD)) begin
                card_cycle_in_progress <= 1'b0;
                char_needed            <= 1'b0;
                read_buffer_full       <= feed && !clear_read_buffer;
                read_data_available    <= feed && !clear_read_buffer;
                cols                   <= 7'(COLS);
            end else if (char_load_pulse) begin
                char_needed <= 1'b0;
            end else if (cnt[2:0] == 3'h0 && !read_buffer_full) begin
                char_needed <= 1'b1;
            end
            if (clear_read_buffer) begin
                read_buffer_full    <= 1'b0;
                read_data_available <= 1'b0;
            end else if (read_transfer_clock) begin
                read_data_available <= 1'b0;
                cols                <= cols - 7'h01;
                if (cols == 7'h01) read_buffer_full <= 1'b0;
            end else if (read_buffer_full) read_data_available <= 1'b1;
        end
    end
endmodule

//--- dv/card_unit_control_interface_bench.sv
`timescale 1ns/1ns
module card_unit_control_interface_bench;
    import cuc_pkg::*;
    logic       ref_clk, sys_rst, exch_load, recirc_load, stc_advance, stc_clear, test_sr_cmd, cycle_req;
    logic       cfg_inhibit_feed, cfg_secondary, cfg_punch, cfg_print, cfg_separate, read_wanted, unit_ready, sb;
    logic [7:0] exch_in, last_out, exp_q[$];
    logic [2:0] cfg_stacker;
    logic [3:0] dly;
    logic       p_start, p_ccl, p_rdy, p_rda;
    wire  [7:0] exch_out, read_data_lines, punch_print_lines;
    wire  [4:0] status_counter, result_status;
    wire  [6:0] byte_counter;
    wire  [2:0] stacker_select_levels;
    wire        exch_out_valid, cycle_busy, card_cycle_in_progress, char_needed, read_buffer_full;
    wire        read_data_available, card_cycle_start, inhibit_feed, separate_print, char_load_pulse;
    wire        clear_read_buffer, read_transfer_clock;
    int         n_mismatch, n_compared, n_xfr, cyc;
    cuc_unit_ctrl dut (.ref_clk, .sys_rst, .exch_in, .exch_load, .recirc_load, .translate_en(1'b0), .exch_out,
        .exch_out_valid, .stc_advance, .stc_clear, .test_sr_cmd, .status_counter, .result_status, .byte_counter,
        .cycle_req, .cfg_inhibit_feed, .cfg_stacker, .cfg_secondary, .cfg_punch, .cfg_print, .cfg_separate,
        .read_wanted, .cycle_busy, .unit_ready, .card_cycle_in_progress, .char_needed, .read_buffer_full,
        .read_data_available, .read_data_lines, .card_cycle_start, .inhibit_feed, .stacker_select_levels,
        .separate_print, .punch_print_lines, .char_load_pulse, .clear_read_buffer, .read_transfer_clock);
    cuc_card_unit_model #(.COLS(96), .HOLD(150)) unit (.ref_clk, .sys_rst, .dly, .unit_ready, .card_cycle_start,
        .inhibit_feed, .char_load_pulse, .clear_read_buffer, .read_transfer_clock, .card_cycle_in_progress,
        .char_needed, .read_buffer_full, .read_data_available, .read_data_lines);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic adv();
        tick(1);
        stc_advance <= 1'b1;
        tick(1);
        stc_advance <= 1'b0;
    endtask
    // one store pass; the next load waits for the capture, as the store refuses overlap
    task automatic load(input logic [7:0] b, input logic rc);
        int t;
        tick(1);
        exch_load   <= !rc;
        recirc_load <= rc;
        exch_in     <= b;
        exp_q.push_back(rc ? last_out : b);
        tick(1);
        {exch_load, recirc_load} <= 2'h0;
        for (t = 0; t < 20 && !exch_out_valid; t++) @(negedge ref_clk);
        if (t == 20) chk(8'h00, 8'h01);
    endtask
    task automatic card(input logic [3:0] d, input logic rw, input logic inh, input logic drop);
        int t, x0;
        x0 = n_xfr;
        tick(1);
        {dly, read_wanted, cfg_inhibit_feed, cycle_req} <= {d, rw, inh, 1'b1};
        tick(1);
        cycle_req <= 1'b0;
        tick(4);
        if (drop) unit_ready <= 1'b0;
        tick(4);
        unit_ready <= 1'b1;
        for (t = 0; t < 900 && (card_cycle_in_progress || read_buffer_full); t++) @(negedge ref_clk);
        chk(8'(n_xfr - x0), (rw && !inh && !drop) ? 8'h60 : 8'h00);
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    always @(negedge ref_clk) begin
        if (!sys_rst) begin
            if (sb && exch_out_valid) begin
                last_out = exp_q.pop_front();
                chk(exch_out, last_out);
            end
            if (char_load_pulse) chk({2'h0, punch_print_lines[5:0]}, {2'h0, last_out[5:0]});
            if (p_start && !p_ccl && p_rdy) chk(8'(card_cycle_start), 8'h01);
            if (p_start && !p_rdy) chk(8'(card_cycle_start), 8'h00);
            if (p_ccl) chk(8'(card_cycle_start), 8'h00);
            if (p_ccl) chk(8'(cycle_busy), 8'h01);
            chk(8'(clear_read_buffer), 8'(read_buffer_full && !read_wanted));
            if (read_transfer_clock) begin
                n_xfr++;
                chk(8'(p_rda), 8'h01);
            end
        end
        {p_start, p_ccl, p_rdy, p_rda} = {card_cycle_start, card_cycle_in_progress, unit_ready, read_data_available};
    end
    initial begin
        int i, n;
        {exch_load, recirc_load, stc_advance, stc_clear, test_sr_cmd, cycle_req, sb} = '0;
        {cfg_inhibit_feed, cfg_secondary, cfg_punch, cfg_print, cfg_separate, cfg_stacker} = '0;
        {exch_in, last_out, dly, n_mismatch, n_compared, n_xfr, cyc} = '0;
        {unit_ready, read_wanted, sys_rst} = 3'h7;
        void'($urandom(32'h0b126ce5));
        tick(4);
        sys_rst <= 1'b0;
        tick(2);
        for (i = 0; i < 8; i++) begin
            tick(1);
            {cfg_secondary, cfg_punch, cfg_print, cfg_separate, cfg_inhibit_feed} <= 5'($urandom);
            cfg_stacker <= i[2:0];
            tick(3);
            @(negedge ref_clk);
            chk(8'(stacker_select_levels), 8'(cfg_stacker));
            chk(8'(punch_print_lines[3]), 8'(cfg_secondary));
            chk(8'(punch_print_lines[6:5]), 8'({cfg_print, cfg_punch}));
            chk(8'(separate_print), 8'(cfg_separate && cfg_punch && cfg_print));
            chk(8'(inhibit_feed), 8'(cfg_inhibit_feed));
        end
        n = $urandom_range(30, 24);
        repeat (n) adv();
        tick(2);
        @(negedge ref_clk);
        chk(8'(status_counter), 8'(n % 24));
        chk(8'(result_status), 8'(n % 24));
        tick(1);
        test_sr_cmd <= 1'b1;
        adv();
        tick(2);
        @(negedge ref_clk);
        chk(8'(result_status), 8'(n % 24));
        chk(8'(status_counter), 8'((n + 1) % 24));
        tick(1);
        test_sr_cmd <= 1'b0;
        card(4'h0, 1'b1, 1'b0, 1'b0);
        card(4'h9, 1'b0, 1'b0, 1'b0);
        card(4'h2, 1'b1, 1'b1, 1'b0);
        card(4'hc, 1'b1, 1'b0, 1'b1);
        chk(8'(byte_counter), 8'h00);
        tick(1);
        sys_rst <= 1'b1;
        tick(4);
        sys_rst <= 1'b0;
        tick(2);
        // the store keeps its contents through reset, so fill it with known bytes first
        repeat (STORE_DEPTH) load(8'($urandom), 1'b0);
        repeat (10) adv();
        sb = 1'b1;
        {cfg_punch, cfg_inhibit_feed, dly} <= {2'h3, 4'h1};
        for (i = 0; i < 110; i++) begin
            if (i == 96 || i == 97) begin
                tick(1);
                cycle_req <= (i == 96);
            end
            load(8'($urandom), i == 39 || i == 105);
        end
        chk(8'(byte_counter), 8'h6e);
        complete_run();
    end
endmodule
